/* File: acfm_defines.svh */
// Purpose: Constants of the audio clock failure monitor
// Assumes: System clock of 50 MHz
// Notes: Counts, recovery codes and reset values only; types live in acfm_pkg
`ifndef ACFM_DEFINES_SVH
`define ACFM_DEFINES_SVH

// ==========================================================
// Window and count limits
`define ACFM_WINDOW_EDGES 6'h20
`define ACFM_WINDOW_LAST 5'h1f
`define ACFM_WINDOW_RESTART 9'h001
`define ACFM_COUNT_SAT 9'h1ff
`define ACFM_COUNT_MAX8 8'hff
// ==========================================================
// Transmit recovery
`define ACFM_BMC_ZERO_PATTERN 4'hc
`define ACFM_SRC_INTERNAL 1'h1
// ==========================================================
// Reset values
`define ACFM_RST_COUNT 8'h00
`define ACFM_RST_PATTERN 4'h0

`endif

/* File: acfm_pkg.sv */
// Purpose: Types of the audio clock failure monitor
// Assumes: acfm_defines.svh for numbers
// Notes: Whole module state is one packed struct
package acfm_pkg;

  // ==========================================================
  // Software bounds of one checker
  typedef struct packed {
    logic [7:0] lower;
    logic [7:0] upper;
  } acfm_bounds_t;

  // ==========================================================
  // State of one clock checker
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    logic [4:0] edges;
    logic [8:0] running;
    logic [7:0] latched;
    logic fail;
    logic failEvent;
  } acfm_chan_t;

  // ==========================================================
  // State of the whole monitor
  typedef struct packed {
    acfm_chan_t tx;
    acfm_chan_t rx;
    logic irq;
    logic srcSel;
    logic pinOe;
    logic divReset;
    logic secReset;
    logic [7:0] resetCnt;
    logic underrun;
    logic [3:0] pattern;
  } acfm_state_t;

endpackage

/* File: acfm_audio_clock_failure_monitor.sv */
// Purpose: Watch transmit and receive high-frequency serial clocks for failure
// Assumes: Serial clocks are asynchronous pins sampled on the system clock
// Notes: Software fields are plain ports; all outputs come from flip-flops
//        Window count is system cycles per 32 serial periods, clipped at 255
//        A stopped serial clock shows as a live count past the upper bound
//        Autoswitch fires once per newly raised transmit flag
//        Section reset lasts the divide ratio plus one system cycle
`include "acfm_defines.svh"
`timescale 1ns/100ps
`default_nettype none

// How it works
// - Tx: count system clocks per 32 periods
// - Rx: count system clocks per 32 periods
// - Latched count below minimum flags failure
// - Running count above maximum flags failure
// - Eight-bit bounds, unsigned comparisons
// - Tx fail flag; interrupt only when enabled
// - Rx fail flag set; it drives no interrupt
// - Autoswitch only if enabled and S/PDIF mode
// - Select internal source; pin input while Tx flag stands
// - Reset internal divider, ratio kept
// - Hold transmitter reset one serial period
// - Release: send data or underrun pattern 1100
module acfm_audio_clock_failure_monitor (
  input wire logic clock,
  input wire logic rstn,
  input wire logic txHfSerialClock,
  input wire logic rxHfSerialClock,
  input wire logic txCheckerActive,
  input wire logic rxCheckerActive,
  input wire acfm_pkg::acfm_bounds_t txBounds,
  input wire acfm_pkg::acfm_bounds_t rxBounds,
  input wire logic txFailClear,
  input wire logic rxFailClear,
  input wire logic txFailIntEnable,
  input wire logic txFailAutoswitchEnable,
  input wire logic spdifTransmitMode,
  input wire logic txSrcSelWrite,
  input wire logic txSrcSelValue,
  input wire logic txPinDirOut,
  input wire logic [7:0] txHfDivideRatio,
  input wire logic txDataWaiting,
  output logic [7:0] txWindowCount,
  output logic [7:0] rxWindowCount,
  output logic txClockFailFlag,
  output logic rxClockFailFlag,
  output logic txFailIrq,
  output logic txHfClockSourceSelect,
  output logic txHfPinOutputEnable,
  output logic txDividerReset,
  output logic txSectionReset,
  output logic txUnderrun,
  output logic [3:0] txShiftPattern
);
  import acfm_pkg::*;

  acfm_state_t state_reg;
  acfm_state_t state_next;

  // ==========================================================
  // One checker step
  // sync1 and sync2 retime the pin; prev marks its rising edge
  // edges counts closed periods; running counts system cycles
  // latched holds the count software reads back
  function automatic acfm_chan_t chanStep(
    input acfm_chan_t c,
    input logic clkPin,
    input acfm_bounds_t b,
    input logic active,
    input logic clr
  );
    acfm_chan_t n;
    logic [7:0] cnt8;
    n = c;
    // Latched field clips at its top value
    cnt8 = (c.running > {1'b0, `ACFM_COUNT_MAX8}) ? `ACFM_COUNT_MAX8 : c.running[7:0];
    // Only the second stage feeds logic
    n.sync1 = clkPin;
    n.sync2 = c.sync1;
    n.prev = c.sync2;
    n.failEvent = 1'b0;
    // Divider held: no counting, no failure
    if (!active)
    begin
      n.edges = 5'h00;
      n.running = 9'h000;
    end
    else
    begin
      if (c.running != `ACFM_COUNT_SAT)
      begin
        n.running = c.running + 9'h001;
      end
      if (c.sync2 && !c.prev)
      begin
        n.edges = c.edges + 5'h01;
        if (c.edges == `ACFM_WINDOW_LAST)
        begin
          n.latched = cnt8;
          // Closing cycle already belongs to the next window
          n.running = `ACFM_WINDOW_RESTART;
          if (cnt8 < b.lower)
          begin
            n.failEvent = 1'b1;
          end
        end
      end
      // Live count, so a pin that stops still fails
      if (c.running > {1'b0, b.upper})
      begin
        n.failEvent = 1'b1;
      end
    end
    // Set wins over clear
    n.fail = n.failEvent | (c.fail & ~clr);
    return n;
  endfunction

  // ==========================================================
  // Next state
  always_comb
  begin
    logic autoSwitch;
    logic freshFail;
    autoSwitch = 1'b0;
    freshFail = 1'b0;
    state_next = state_reg;
    state_next.tx = chanStep(
      state_reg.tx,
      txHfSerialClock,
      txBounds,
      txCheckerActive,
      txFailClear
    );
    state_next.rx = chanStep(
      state_reg.rx,
      rxHfSerialClock,
      rxBounds,
      rxCheckerActive,
      rxFailClear
    );
    // Interrupt gated by its enable; the flag sets regardless
    state_next.irq = state_next.tx.fail & txFailIntEnable;
    state_next.divReset = 1'b0;
    // Only a newly raised flag switches; a standing one would keep resetting the transmitter
    freshFail = state_next.tx.failEvent & ~state_reg.tx.fail;
    autoSwitch = freshFail & txFailAutoswitchEnable & spdifTransmitMode & ~state_reg.secReset;
    // Software write of the source select
    if (txSrcSelWrite)
    begin
      state_next.srcSel = txSrcSelValue;
    end
    // Section reset lasts one serial period, ratio plus one cycles
    if (state_reg.secReset)
    begin
      if (state_reg.resetCnt == `ACFM_RST_COUNT)
      begin
        state_next.secReset = 1'b0;
        state_next.underrun = ~txDataWaiting;
      end
      else
      begin
        state_next.resetCnt = state_reg.resetCnt - 8'h01;
      end
    end
    // Underrun ends as soon as data waits
    else if (state_reg.underrun && txDataWaiting)
    begin
      state_next.underrun = 1'b0;
    end
    // Move to the internal divider and restart the transmitter
    if (autoSwitch)
    begin
      state_next.srcSel = `ACFM_SRC_INTERNAL;
      state_next.divReset = 1'b1;
      state_next.secReset = 1'b1;
      state_next.resetCnt = txHfDivideRatio;
      state_next.underrun = 1'b0;
    end
    state_next.pattern = state_next.underrun ? `ACFM_BMC_ZERO_PATTERN : `ACFM_RST_PATTERN;
    // Pin stays an input while the transmit flag stands
    state_next.pinOe = state_next.srcSel & txPinDirOut & ~state_next.tx.fail;
  end

  // ==========================================================
  // State register
  // Reset: external source, no failure, transmitter out of reset
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // Outputs
  // Every output is a field of the state register
  assign txWindowCount = state_reg.tx.latched;
  assign rxWindowCount = state_reg.rx.latched;
  assign txClockFailFlag = state_reg.tx.fail;
  assign rxClockFailFlag = state_reg.rx.fail;
  assign txFailIrq = state_reg.irq;
  assign txHfClockSourceSelect = state_reg.srcSel;
  assign txHfPinOutputEnable = state_reg.pinOe;
  assign txDividerReset = state_reg.divReset;
  assign txSectionReset = state_reg.secReset;
  assign txUnderrun = state_reg.underrun;
  assign txShiftPattern = state_reg.pattern;

endmodule

`default_nettype wire

/* File: acfm_clk_src.sv */
// Purpose: Serial clock source model
// Assumes: Half period in system cycles
// Notes: Pin rests low while stopped
`timescale 1ns/100ps
`default_nettype none
module acfm_clk_src (
  input wire logic clock,
  input wire logic run,
  input wire logic [3:0] half,
  output logic hfClk
);
  logic [3:0] cnt = 4'h0;
  initial hfClk = 1'b0;
  always @(posedge clock)
  begin
    cnt <= (!run || cnt == half - 4'h1) ? 4'h0 : cnt + 4'h1;
    hfClk <= run && ((cnt == half - 4'h1) ? !hfClk : hfClk);
  end
endmodule
`default_nettype wire

/* File: acfm_monitor_chk.sv */
// Purpose: Port checks of the monitor
// Assumes: One clock domain
// Notes: Bound to the top module
`timescale 1ns/100ps
`default_nettype none
module acfm_monitor_chk (
  input wire logic clock,
  input wire logic rstn,
  input wire logic txCheckerActive,
  input wire logic rxCheckerActive,
  input wire logic txFailIntEnable,
  input wire logic txFailAutoswitchEnable,
  input wire logic spdifTransmitMode,
  input wire logic txClockFailFlag,
  input wire logic rxClockFailFlag,
  input wire logic txFailIrq,
  input wire logic txHfClockSourceSelect,
  input wire logic txHfPinOutputEnable,
  input wire logic txDividerReset,
  input wire logic txSectionReset,
  input wire logic txUnderrun,
  input wire logic [3:0] txShiftPattern
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  a_irq_needs_enable: assert property (!$past(txFailIntEnable) |-> !txFailIrq) else $error("irq");
  a_tx_idle_quiet: assert property (!txCheckerActive[*3] ##0 !txClockFailFlag |=> !txClockFailFlag) else $error("tx");
  a_rx_idle_quiet: assert property (!rxCheckerActive[*3] ##0 !rxClockFailFlag |=> !rxClockFailFlag) else $error("rx");
  a_div_one_pulse: assert property (txDividerReset |=> !txDividerReset) else $error("div");
  a_switch_state: assert property (txDividerReset |-> txHfClockSourceSelect && txSectionReset && txClockFailFlag)
    else $error("switch");
  a_switch_needs_mode: assert property (txDividerReset |-> $past(spdifTransmitMode) && $past(txFailAutoswitchEnable))
    else $error("mode");
  a_pin_held_input: assert property (txClockFailFlag |-> !txHfPinOutputEnable) else $error("pin");
  a_pattern_match: assert property (txShiftPattern == (txUnderrun ? 4'hc : 4'h0)) else $error("pattern");
  a_section_release: assert property ($rose(txSectionReset) |-> ##[1:257] !txSectionReset) else $error("hold");
endmodule
bind acfm_audio_clock_failure_monitor acfm_monitor_chk chk (
  .clock(clock),
  .rstn(rstn),
  .txCheckerActive(txCheckerActive),
  .rxCheckerActive(rxCheckerActive),
  .txFailIntEnable(txFailIntEnable),
  .txFailAutoswitchEnable(txFailAutoswitchEnable),
  .spdifTransmitMode(spdifTransmitMode),
  .txClockFailFlag(txClockFailFlag),
  .rxClockFailFlag(rxClockFailFlag),
  .txFailIrq(txFailIrq),
  .txHfClockSourceSelect(txHfClockSourceSelect),
  .txHfPinOutputEnable(txHfPinOutputEnable),
  .txDividerReset(txDividerReset),
  .txSectionReset(txSectionReset),
  .txUnderrun(txUnderrun),
  .txShiftPattern(txShiftPattern)
);
`default_nettype wire

/* File: testbench.sv */
// Purpose: Bench of the clock failure monitor
// Assumes: Serial periods 4 and 6 cycles
// Notes: Ratio 3 gives a 4-cycle reset
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import acfm_pkg::*;
  logic clock = 1'b0, rstn = 1'b0, txRun = 1'b0, rxRun = 1'b0, txHfSerialClock, rxHfSerialClock;
  logic txCheckerActive = 1'b0, rxCheckerActive = 1'b0, txFailClear = 1'b0, rxFailClear = 1'b0;
  logic txFailIntEnable = 1'b0, txFailAutoswitchEnable = 1'b0, spdifTransmitMode = 1'b0, txSrcSelWrite = 1'b0;
  logic txSrcSelValue = 1'b0, txPinDirOut = 1'b1, txDataWaiting = 1'b0, txClockFailFlag, rxClockFailFlag, txFailIrq;
  logic txHfClockSourceSelect, txHfPinOutputEnable, txDividerReset, txSectionReset, txUnderrun;
  logic [7:0] txHfDivideRatio = 8'h03, txWindowCount, rxWindowCount;
  logic [3:0] txShiftPattern;
  acfm_bounds_t txBounds = {8'h64, 8'hc8}, rxBounds = {8'h64, 8'hc8};
  int failures = 0, tests_run = 0, n;
  acfm_audio_clock_failure_monitor DUT (
    .clock(clock), .rstn(rstn), .txHfSerialClock(txHfSerialClock), .rxHfSerialClock(rxHfSerialClock),
    .txCheckerActive(txCheckerActive), .rxCheckerActive(rxCheckerActive), .txBounds(txBounds),
    .rxBounds(rxBounds), .txFailClear(txFailClear), .rxFailClear(rxFailClear),
    .txFailIntEnable(txFailIntEnable), .txFailAutoswitchEnable(txFailAutoswitchEnable),
    .spdifTransmitMode(spdifTransmitMode), .txSrcSelWrite(txSrcSelWrite), .txSrcSelValue(txSrcSelValue),
    .txPinDirOut(txPinDirOut), .txHfDivideRatio(txHfDivideRatio), .txDataWaiting(txDataWaiting),
    .txWindowCount(txWindowCount), .rxWindowCount(rxWindowCount), .txClockFailFlag(txClockFailFlag),
    .rxClockFailFlag(rxClockFailFlag), .txFailIrq(txFailIrq),
    .txHfClockSourceSelect(txHfClockSourceSelect), .txHfPinOutputEnable(txHfPinOutputEnable),
    .txDividerReset(txDividerReset), .txSectionReset(txSectionReset), .txUnderrun(txUnderrun),
    .txShiftPattern(txShiftPattern)
  );
  acfm_clk_src txSrc (.clock(clock), .run(txRun), .half(4'h2), .hfClk(txHfSerialClock));
  acfm_clk_src rxSrc (.clock(clock), .run(rxRun), .half(4'h3), .hfClk(rxHfSerialClock));
  initial
  begin
    forever #10 clock = ~clock;
  end
  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic test_done;
    $display("Checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic settle(input int k);
    repeat (k) @(posedge clock);
    @(negedge clock);
  endtask
  initial
  begin
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    txCheckerActive <= 1'b1;
    rxCheckerActive <= 1'b1;
    txRun <= 1'b1;
    rxRun <= 1'b1;
    repeat (600) @(posedge clock);
    txFailClear <= 1'b1;
    rxFailClear <= 1'b1;
    @(posedge clock);
    txFailClear <= 1'b0;
    rxFailClear <= 1'b0;
    settle(400);
    chk("txCount", 9'h080, {1'b0, txWindowCount});
    chk("rxCount", 9'h0c0, {1'b0, rxWindowCount});
    chk("txFail", 9'h000, {8'h00, txClockFailFlag});
    chk("rxFail", 9'h000, {8'h00, rxClockFailFlag});
    @(posedge clock);
    txBounds.lower <= 8'h81;
    txFailIntEnable <= 1'b1;
    txFailAutoswitchEnable <= 1'b1;
    settle(300);
    chk("txFail", 9'h001, {8'h00, txClockFailFlag});
    chk("txIrq", 9'h001, {8'h00, txFailIrq});
    chk("srcSel", 9'h000, {8'h00, txHfClockSourceSelect});
    @(posedge clock);
    txFailIntEnable <= 1'b0;
    txBounds.lower <= 8'h64;
    settle(3);
    chk("txIrq", 9'h000, {8'h00, txFailIrq});
    @(posedge clock);
    txFailClear <= 1'b1;
    spdifTransmitMode <= 1'b1;
    txRun <= 1'b0;
    @(posedge clock);
    txFailClear <= 1'b0;
    for (n = 0; txSectionReset !== 1'b1 && n < 500; n++)
      @(negedge clock);
    chk("divReset", 9'h001, {8'h00, txDividerReset});
    for (n = 0; txSectionReset === 1'b1 && n < 300; n++)
      @(negedge clock);
    chk("resetCycles", 9'h004, n[8:0]);
    chk("srcSel", 9'h001, {8'h00, txHfClockSourceSelect});
    chk("pinOe", 9'h000, {8'h00, txHfPinOutputEnable});
    chk("underrun", 9'h001, {8'h00, txUnderrun});
    chk("pattern", 9'h00c, {5'h00, txShiftPattern});
    @(posedge clock);
    rxRun <= 1'b0;
    settle(300);
    chk("rxFail", 9'h001, {8'h00, rxClockFailFlag});
    chk("secReset", 9'h000, {8'h00, txSectionReset});
    @(posedge clock);
    txDataWaiting <= 1'b1;
    settle(2);
    chk("underrun", 9'h000, {8'h00, txUnderrun});
    chk("pattern", 9'h000, {5'h00, txShiftPattern});
    @(posedge clock);
    txSrcSelWrite <= 1'b1;
    txCheckerActive <= 1'b0;
    rxCheckerActive <= 1'b0;
    txFailClear <= 1'b1;
    rxFailClear <= 1'b1;
    @(posedge clock);
    txSrcSelWrite <= 1'b0;
    txFailClear <= 1'b0;
    rxFailClear <= 1'b0;
    settle(20);
    chk("srcSel", 9'h000, {8'h00, txHfClockSourceSelect});
    chk("txFail", 9'h000, {8'h00, txClockFailFlag});
    chk("rxFail", 9'h000, {8'h00, rxClockFailFlag});
    test_done;
  end
  initial
  begin
    #100us;
    failures++;
    test_done;
  end
endmodule
`default_nettype wire
